// file: include/rltm_pkg.sv
package rltm_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CYCLE_MS = 1000;
  localparam int unsigned CYCLE_CYC = CLK_HZ / 1000 * CYCLE_MS;
  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  // Register offsets
  localparam logic [7:0] REG_LOC_MSB = 8'h00;
  localparam logic [7:0] REG_REM_MSB = 8'h01;
  localparam logic [7:0] REG_STATUS1 = 8'h02;
  localparam logic [7:0] REG_CFG1 = 8'h03;
  localparam logic [7:0] REG_RATE = 8'h04;
  localparam logic [7:0] REG_RATE_W = 8'h0A;
  localparam logic [7:0] REG_ROS_LIM = 8'h07;
  localparam logic [7:0] REG_ONESHOT = 8'h0F;
  localparam logic [7:0] REG_REM_LSB = 8'h10;
  localparam logic [7:0] REG_OFF_HI = 8'h11;
  localparam logic [7:0] REG_OFF_LO = 8'h12;
  localparam logic [7:0] REG_RCRIT_LIM = 8'h19;
  localparam logic [7:0] REG_LOC_LIM = 8'h20;
  localparam logic [7:0] REG_LOC_LSB = 8'h30;
  localparam logic [7:0] REG_REMU_MSB = 8'h31;
  localparam logic [7:0] REG_REMU_LSB = 8'h32;
  localparam logic [7:0] REG_CFG2 = 8'hBF;
  // Reset values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h02;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h1F;
  localparam logic [7:0] ROS_LIM_RST = 8'h55;
  localparam logic [7:0] LOC_LIM_RST = 8'h55;
  localparam logic [7:0] RCRIT_LIM_RST = 8'h6E;
  localparam logic [7:0] OFF_RST = 8'h00;
  // Field positions
  localparam int CFG1_ROS_MASK = 0;
  localparam int CFG1_RCRIT_MASK = 1;
  localparam int CFG1_LOS_MASK = 2;
  localparam int CFG1_LCRIT_MASK = 3;
  localparam int CFG1_STANDBY = 6;
  localparam int CFG2_FE_LOW = 1;
  localparam int CFG2_FE_HIGH = 2;
  localparam int CFG2_PIN_ADDR = 4;
  localparam int ST_ROS = 0;
  localparam int ST_RCRIT = 1;
  localparam int ST_LOC = 4;
  localparam int ST_BUSY = 7;
  localparam int LOC_LIM_W = 7;
  // Conversion rate codes
  localparam logic [1:0] RATE_CONT = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_ONE = 2'h2;
  // Address pin levels and slave addresses
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [6:0] ADDR_LOW = 7'h18;
  localparam logic [6:0] ADDR_MID = 7'h29;
  localparam logic [6:0] ADDR_HIGH = 7'h4C;
  localparam logic [6:0] ADDR_ALT_LOW = 7'h19;
  localparam logic [6:0] ADDR_ALT_HIGH = 7'h4D;
  localparam logic [12:0] SGN_MAX = 13'h0FFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    SM_IDLE, SM_ADDR, SM_A_ACK, SM_CMD, SM_C_ACK, SM_WDATA, SM_W_ACK, SM_RDATA, SM_M_ACK
  } rltm_sm_t;
  typedef enum logic [1:0] {CV_IDLE, CV_LOCAL, CV_REMOTE, CV_WAIT} rltm_cv_t;
endpackage : rltm_pkg

// file: rtl/rltm_core.sv
`timescale 1ns/1ps
// Contract
// - Local reading compared with shared local limit; masks gate both alerts.
// - Remote reading compared with critical and overtemperature limits, masks gate alerts.
// - Comparison results are readable in status register one.
// - Both alerts are active low open-drain: pull low or release.
// - Filtered remote value feeds the limit comparisons when filter is on.
// - Standby bit stops periodic conversions; serial slave keeps working.
// - One-shot write in standby converts both channels once, then updates alerts.
// - Readings are left-justified 16-bit words; local is ten bits plus sign.
// - Remote reading given both as 13-bit unsigned and 12-bit plus sign.
// - Lowest two remote bits read zero while the filter is off.
// - Limits unsigned, 1 degree LSB; local limit 7 bits, remote 8 bits.
// - Channels convert alternately; default full cycle takes at least one second.
// - Status bit 7 high only while a conversion is running.
// - Rate field sets the period from one conversion start to the next, conversion time included.
// - Pointer resets to 00h, rate to 02h, readings zero until converted.
// - Limit and offset registers take their power-up defaults.
// - Configuration one resets to 00h: run mode, all masks clear.
// - Configuration two resets to 1Fh: filter on, pin is address input.
// - Slave only, 7-bit address, never drives clock, never stretches.
// - Three-level pin picks address 18h, 29h or 4Ch (variant 19h, 29h, 4Dh).
// - Shared pin becomes alert output only while high, fixing address 4Ch.
// - As address input, the pin level sets the address live, unlatched.
// - Clock or data low past timeout resets the slave and frees lines.
// - Filter bits 11 turn the filter on, 00 off, others reserved.
module rltm_core #(
  parameter int unsigned CYCLE_CYC_P = rltm_pkg::CYCLE_CYC,
  parameter int unsigned TIMEOUT_CYC_P = rltm_pkg::TIMEOUT_CYC,
  parameter bit ALT_ADDR = 1'b0
) (
  // System clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Front-end link clock and reset
  input wire logic afe_clk,
  input wire logic afe_rst_n,
  // Serial bus pins
  input wire logic smb_clk_in,
  input wire logic smb_dat_in,
  output logic smb_dat_out,
  output logic smb_dat_oe,
  // Three-level address detector
  input wire logic [1:0] addr_level_in,
  // Alert pins, open drain
  output logic critical_alert_out_n_out,
  output logic critical_alert_out_n_oe,
  output logic shared_alert_address_pin_out,
  output logic shared_alert_address_pin_oe,
  // Front-end control, reference domain
  output logic afe_power_down,
  output logic remote_filter_on,
  // Front-end handshake, link domain
  output logic afe_start,
  output logic afe_channel,
  input wire logic afe_done,
  input wire logic [10:0] afe_local,
  input wire logic [13:0] afe_remote_raw,
  input wire logic [13:0] afe_remote_filt
);

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic [2:0][1:0] lvl_s;
    logic [1:0] lvl_f;
    rltm_pkg::rltm_sm_t ph;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic [7:0] ptr;
    logic sda_oe;
    logic dat_o;
    logic [31:0] to_ctr;
    rltm_pkg::rltm_cv_t cph;
    logic [31:0] per_ctr;
    logic req_tog;
    logic chan;
    logic [2:0] ack_s;
    logic ack_seen;
    logic os_pend;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] rate;
    logic [7:0] loc_lim;
    logic [7:0] rcrit_lim;
    logic [7:0] ros_lim;
    logic [7:0] off_hi;
    logic [7:0] off_lo;
    logic [10:0] loc_t;
    logic [13:0] rem_t;
    logic loc_hi;
    logic rem_crit;
    logic rem_os;
    logic crit_oe;
    logic os_act;
    logic os_pin_oe;
    logic pwr_dn;
    logic filt_o;
  } rltm_ref_t;

  typedef struct packed {
    logic [2:0] req_s;
    logic req_seen;
    logic busy;
    logic start;
    logic ch;
    logic [10:0] h_loc;
    logic [13:0] h_raw;
    logic [13:0] h_filt;
    logic ack_tog;
  } rltm_afe_t;

  rltm_ref_t r;
  rltm_ref_t n;
  rltm_afe_t q;
  rltm_afe_t m;
  logic rise, fall, start, stop, timeout, wr, os_hit, ack_evt, filt, standby;
  logic [7:0] rdv;
  logic [6:0] slave_addr;
  logic [13:0] rem_sel;
  logic [15:0] rem_s, rem_u;
  logic [31:0] per_tgt;
  logic rc, ro, crit, osa;

  // Remote word as signed or unsigned left-justified reading
  function automatic logic [15:0] rem_word(input logic [13:0] t, input logic uns,
                                           input logic f);
    logic [12:0] v;
    v = t[12:0];
    if (uns && t[13]) begin
      v = '0;
    end else if (!uns && !t[13] && t[12]) begin
      v = rltm_pkg::SGN_MAX;
    end
    if (!f) begin
      v[1:0] = 2'h0;
    end
    return {v, 3'h0};
  endfunction : rem_word

  // Reference-domain next state: pins, serial slave, registers, sequencer
  always_comb begin
    n = r;
    rdv = '0;
    wr = 1'b0;
    os_hit = 1'b0;
    rem_sel = '0;
    rc = 1'b0;
    ro = 1'b0;
    crit = 1'b0;
    osa = 1'b0;
    // Three-stage sampling; a change counts once stages two and three agree
    n.scl_s = {r.scl_s[1:0], smb_clk_in};
    n.sda_s = {r.sda_s[1:0], smb_dat_in};
    n.lvl_s = {r.lvl_s[1:0], addr_level_in};
    if (r.scl_s[1] == r.scl_s[2]) n.scl_f = r.scl_s[2];
    if (r.sda_s[1] == r.sda_s[2]) n.sda_f = r.sda_s[2];
    if (r.lvl_s[1] == r.lvl_s[2]) n.lvl_f = r.lvl_s[2];
    rise = n.scl_f & ~r.scl_f;
    fall = ~n.scl_f & r.scl_f;
    start = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;
    stop = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;
    // Filter decode, reserved patterns act as off
    filt = r.cfg2[rltm_pkg::CFG2_FE_HIGH] & r.cfg2[rltm_pkg::CFG2_FE_LOW];
    standby = r.cfg1[rltm_pkg::CFG1_STANDBY];
    // Full words first, so each byte lane is a plain part-select
    rem_s = rem_word(r.rem_t, 1'b0, filt);
    rem_u = rem_word(r.rem_t, 1'b1, filt);
    // Alert mode pins the address; else live pin level
    if (!r.cfg2[rltm_pkg::CFG2_PIN_ADDR]) begin
      slave_addr = rltm_pkg::ADDR_HIGH;
    end else if (r.lvl_f == rltm_pkg::LVL_LOW) begin
      slave_addr = ALT_ADDR ? rltm_pkg::ADDR_ALT_LOW : rltm_pkg::ADDR_LOW;
    end else if (r.lvl_f == rltm_pkg::LVL_MID) begin
      slave_addr = rltm_pkg::ADDR_MID;
    end else begin
      slave_addr = ALT_ADDR ? rltm_pkg::ADDR_ALT_HIGH : rltm_pkg::ADDR_HIGH;
    end
    // Read-back mux; readings left-justified
    case (r.ptr)
      rltm_pkg::REG_LOC_MSB: rdv = r.loc_t[10:3];
      rltm_pkg::REG_LOC_LSB: rdv = {r.loc_t[2:0], 5'h00};
      rltm_pkg::REG_REM_MSB: rdv = rem_s[15:8];
      rltm_pkg::REG_REM_LSB: rdv = rem_s[7:0];
      rltm_pkg::REG_REMU_MSB: rdv = rem_u[15:8];
      rltm_pkg::REG_REMU_LSB: rdv = rem_u[7:0];
      rltm_pkg::REG_STATUS1: begin
        rdv[rltm_pkg::ST_BUSY] = (r.cph == rltm_pkg::CV_LOCAL) || (r.cph == rltm_pkg::CV_REMOTE);
        rdv[rltm_pkg::ST_LOC] = r.loc_hi;
        rdv[rltm_pkg::ST_RCRIT] = r.rem_crit;
        rdv[rltm_pkg::ST_ROS] = r.rem_os;
      end
      rltm_pkg::REG_CFG1: rdv = r.cfg1;
      rltm_pkg::REG_CFG2: rdv = r.cfg2;
      rltm_pkg::REG_RATE: rdv = r.rate;
      rltm_pkg::REG_LOC_LIM: rdv = r.loc_lim;
      rltm_pkg::REG_RCRIT_LIM: rdv = r.rcrit_lim;
      rltm_pkg::REG_ROS_LIM: rdv = r.ros_lim;
      rltm_pkg::REG_OFF_HI: rdv = r.off_hi;
      rltm_pkg::REG_OFF_LO: rdv = r.off_lo;
      default: rdv = '0;
    endcase
    // Bus stuck low: count, then give up the transfer
    timeout = r.to_ctr >= TIMEOUT_CYC_P - 1;
    if (n.scl_f && n.sda_f) begin
      n.to_ctr = '0;
    end else if (!timeout) begin
      n.to_ctr = r.to_ctr + 32'h1;
    end
    // Slave engine; SDA only, clock is never held
    if (timeout) begin
      n.ph = rltm_pkg::SM_IDLE;
      n.sda_oe = 1'b0;
    end else if (start) begin
      n.ph = rltm_pkg::SM_ADDR;
      n.cnt = '0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.ph = rltm_pkg::SM_IDLE;
      n.sda_oe = 1'b0;
    end else if (rise) begin
      unique case (r.ph)
        rltm_pkg::SM_ADDR, rltm_pkg::SM_CMD, rltm_pkg::SM_WDATA: begin
          n.sh = {r.sh[6:0], n.sda_f};
          n.cnt = r.cnt + 4'h1;
        end
        rltm_pkg::SM_RDATA: n.cnt = r.cnt + 4'h1;
        // Host acknowledge repeats the read, no acknowledge ends it
        rltm_pkg::SM_M_ACK: n.ph = n.sda_f ? rltm_pkg::SM_IDLE : rltm_pkg::SM_A_ACK;
        default: ;
      endcase
    end else if (fall) begin
      unique case (r.ph)
        rltm_pkg::SM_ADDR: if (r.cnt == rltm_pkg::BITS_PER_BYTE) begin
          if (r.sh[7:1] == slave_addr) begin
            n.sda_oe = 1'b1;
            n.rw = r.sh[0];
            n.ph = rltm_pkg::SM_A_ACK;
          end else begin
            n.ph = rltm_pkg::SM_IDLE;
          end
        end
        rltm_pkg::SM_A_ACK: begin
          n.cnt = '0;
          n.sda_oe = 1'b0;
          n.ph = rltm_pkg::SM_CMD;
          if (r.rw) begin
            n.sda_oe = ~rdv[7];
            n.sh = {rdv[6:0], 1'b0};
            n.ph = rltm_pkg::SM_RDATA;
          end
        end
        rltm_pkg::SM_CMD: if (r.cnt == rltm_pkg::BITS_PER_BYTE) begin
          n.ptr = r.sh;
          n.sda_oe = 1'b1;
          n.ph = rltm_pkg::SM_C_ACK;
        end
        rltm_pkg::SM_C_ACK: begin
          n.sda_oe = 1'b0;
          n.cnt = '0;
          n.ph = rltm_pkg::SM_WDATA;
        end
        rltm_pkg::SM_WDATA: if (r.cnt == rltm_pkg::BITS_PER_BYTE) begin
          wr = 1'b1;
          n.sda_oe = 1'b1;
          n.ph = rltm_pkg::SM_W_ACK;
        end
        rltm_pkg::SM_W_ACK: begin
          n.sda_oe = 1'b0;
          n.ph = rltm_pkg::SM_IDLE;
        end
        rltm_pkg::SM_RDATA: begin
          if (r.cnt == rltm_pkg::BITS_PER_BYTE) begin
            n.sda_oe = 1'b0;
            n.ph = rltm_pkg::SM_M_ACK;
          end else begin
            n.sda_oe = ~r.sh[7];
            n.sh = {r.sh[6:0], 1'b0};
          end
        end
        default: ;
      endcase
    end
    // Register writes at the pointer; local limit keeps 7 bits
    if (wr) begin
      case (r.ptr)
        rltm_pkg::REG_CFG1: n.cfg1 = r.sh;
        rltm_pkg::REG_RATE, rltm_pkg::REG_RATE_W: n.rate = r.sh;
        rltm_pkg::REG_CFG2: begin
          n.cfg2 = r.sh;
          // Alert mode only accepted while the pin is high
          if (r.lvl_f != rltm_pkg::LVL_HIGH) n.cfg2[rltm_pkg::CFG2_PIN_ADDR] = 1'b1;
        end
        rltm_pkg::REG_LOC_LIM: n.loc_lim = {1'b0, r.sh[rltm_pkg::LOC_LIM_W-1:0]};
        rltm_pkg::REG_RCRIT_LIM: n.rcrit_lim = r.sh;
        rltm_pkg::REG_ROS_LIM: n.ros_lim = r.sh;
        rltm_pkg::REG_OFF_HI: n.off_hi = r.sh;
        rltm_pkg::REG_OFF_LO: n.off_lo = r.sh;
        // Value dropped, only the trigger is kept
        rltm_pkg::REG_ONESHOT: os_hit = standby;
        default: ;
      endcase
    end
    // Front-end answer arrives as a toggle through three stages
    n.ack_s = {r.ack_s[1:0], q.ack_tog};
    ack_evt = (r.ack_s[1] == r.ack_s[2]) && (r.ack_s[2] != r.ack_seen);
    if (ack_evt) n.ack_seen = r.ack_s[2];
    if (r.per_ctr != '1) n.per_ctr = r.per_ctr + 32'h1;
    // Rate code sets the start-to-start period; conversion time counts within it
    unique case (r.rate[1:0])
      rltm_pkg::RATE_CONT: per_tgt = '0;
      rltm_pkg::RATE_HALF: per_tgt = (CYCLE_CYC_P >> 1) - 1;
      rltm_pkg::RATE_ONE: per_tgt = CYCLE_CYC_P - 1;
      default: per_tgt = (CYCLE_CYC_P << 1) - 1;
    endcase
    // Round robin sequencer, local then remote
    unique case (r.cph)
      rltm_pkg::CV_IDLE: begin
        if (!standby || r.os_pend) begin
          n.os_pend = 1'b0;
          n.chan = 1'b0;
          n.req_tog = ~r.req_tog;
          n.per_ctr = '0;
          n.cph = rltm_pkg::CV_LOCAL;
        end
      end
      rltm_pkg::CV_LOCAL: if (ack_evt) begin
        // Reading replaces zero only here; local compare
        n.loc_t = q.h_loc;
        n.loc_hi = !q.h_loc[10] && (q.h_loc[9:3] > r.loc_lim[rltm_pkg::LOC_LIM_W-1:0]);
        n.chan = 1'b1;
        n.req_tog = ~r.req_tog;
        n.cph = rltm_pkg::CV_REMOTE;
      end
      rltm_pkg::CV_REMOTE: if (ack_evt) begin
        rem_sel = filt ? q.h_filt : q.h_raw;
        // Remote compares on the unsigned integer part
        rc = !rem_sel[13] && (rem_sel[12:5] > r.rcrit_lim);
        ro = !rem_sel[13] && (rem_sel[12:5] > r.ros_lim);
        n.rem_t = rem_sel;
        n.rem_crit = rc;
        n.rem_os = ro;
        // Alerts follow the finished pair of results
        crit = (r.loc_hi & ~r.cfg1[rltm_pkg::CFG1_LCRIT_MASK])
             | (rc & ~r.cfg1[rltm_pkg::CFG1_RCRIT_MASK]);
        osa = (r.loc_hi & ~r.cfg1[rltm_pkg::CFG1_LOS_MASK])
            | (ro & ~r.cfg1[rltm_pkg::CFG1_ROS_MASK]);
        n.crit_oe = crit;
        n.os_act = osa;
        n.cph = rltm_pkg::CV_WAIT;
      end
      rltm_pkg::CV_WAIT: begin
        if (standby || r.per_ctr >= per_tgt) n.cph = rltm_pkg::CV_IDLE;
      end
    endcase
    // One-shot request set after the clear, so a late write is kept
    if (os_hit) n.os_pend = 1'b1;
    // Open drain: pull low only while the alert is active
    n.os_pin_oe = r.os_act & ~r.cfg2[rltm_pkg::CFG2_PIN_ADDR];
    n.pwr_dn = standby && (r.cph == rltm_pkg::CV_IDLE);
    n.filt_o = filt;
    n.dat_o = 1'b0;
  end

  // Reference-domain state; power-up values
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r <= '{ph: rltm_pkg::SM_IDLE, cph: rltm_pkg::CV_IDLE, ptr: rltm_pkg::PTR_RST,
             rate: rltm_pkg::RATE_RST, cfg1: rltm_pkg::CFG1_RST, cfg2: rltm_pkg::CFG2_RST,
             loc_lim: rltm_pkg::LOC_LIM_RST, ros_lim: rltm_pkg::ROS_LIM_RST,
             rcrit_lim: rltm_pkg::RCRIT_LIM_RST, off_hi: rltm_pkg::OFF_RST,
             off_lo: rltm_pkg::OFF_RST, scl_s: '1, sda_s: '1, scl_f: 1'b1, sda_f: 1'b1,
             default: '0}; // Pins start idle high, so no false edge follows reset
    end else begin
      r <= n;
    end
  end

  // Link-domain handshake with the front end; request word is stable by then
  always_comb begin
    m = q;
    m.start = 1'b0;
    m.req_s = {q.req_s[1:0], r.req_tog};
    if (!q.busy && q.req_s[1] == q.req_s[2] && q.req_s[2] != q.req_seen) begin
      m.req_seen = q.req_s[2];
      m.start = 1'b1;
      m.ch = r.chan;
      m.busy = 1'b1;
    end else if (q.busy && afe_done) begin
      m.h_loc = afe_local;
      m.h_raw = afe_remote_raw;
      m.h_filt = afe_remote_filt;
      m.busy = 1'b0;
      m.ack_tog = ~q.ack_tog;
    end
  end

  // Link-domain state
  always_ff @(posedge afe_clk) begin
    if (!afe_rst_n) begin
      q <= '0;
    end else begin
      q <= m;
    end
  end

  // Outputs straight from flops
  assign smb_dat_out = r.dat_o;
  assign smb_dat_oe = r.sda_oe;
  assign critical_alert_out_n_out = r.dat_o;
  assign critical_alert_out_n_oe = r.crit_oe;
  assign shared_alert_address_pin_out = r.dat_o;
  assign shared_alert_address_pin_oe = r.os_pin_oe;
  assign afe_power_down = r.pwr_dn;
  assign remote_filter_on = r.filt_o;
  assign afe_start = q.start;
  assign afe_channel = q.ch;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  busy_start_a: assert property (
    $rose(rdv[rltm_pkg::ST_BUSY]) |-> $past(r.cph) == rltm_pkg::CV_IDLE || r.ptr != $past(r.ptr))
    else $error("busy rose without a conversion start");
  standby_hold_a: assert property (
    r.cph == rltm_pkg::CV_IDLE && standby && !r.os_pend |=> r.cph == rltm_pkg::CV_IDLE)
    else $error("conversion started in standby without one-shot");
  oneshot_start_a: assert property (
    os_hit && r.cph == rltm_pkg::CV_IDLE |=> ##[1:2] r.cph == rltm_pkg::CV_LOCAL)
    else $error("one-shot did not start a conversion");
  drain_low_a: assert property (
    critical_alert_out_n_out == 1'b0 && shared_alert_address_pin_out == 1'b0)
    else $error("alert pin driven high");
  addr_release_a: assert property (
    r.cfg2[rltm_pkg::CFG2_PIN_ADDR] ##1 r.cfg2[rltm_pkg::CFG2_PIN_ADDR] |-> !r.os_pin_oe)
    else $error("shared pin driven while address input");
  timeout_free_a: assert property (
    timeout |=> !r.sda_oe && r.ph == rltm_pkg::SM_IDLE)
    else $error("timeout did not release the bus");
  crit_cause_a: assert property (
    r.cph == rltm_pkg::CV_REMOTE && ack_evt |=> r.crit_oe == ((r.rem_crit
      & ~$past(r.cfg1[rltm_pkg::CFG1_RCRIT_MASK]))
      | ($past(r.loc_hi) & ~$past(r.cfg1[rltm_pkg::CFG1_LCRIT_MASK]))))
    else $error("critical alert does not match comparison");
  filt_zero_a: assert property (
    !filt && (r.ptr == rltm_pkg::REG_REM_LSB || r.ptr == rltm_pkg::REG_REMU_LSB) |-> rdv[4:3] == 2'h0)
    else $error("remote low bits nonzero with filter off");
  reset_vals_a: assert property (
    $rose(rst_n) |-> r.rate == rltm_pkg::RATE_RST && r.ptr == rltm_pkg::PTR_RST && r.loc_t == '0)
    else $error("power-up register value wrong");
  cycle_done_c: cover property (r.cph == rltm_pkg::CV_REMOTE ##1 r.cph == rltm_pkg::CV_WAIT);
  oneshot_c: cover property (os_hit && standby);
  read_c: cover property (r.ph == rltm_pkg::SM_M_ACK);
  timeout_c: cover property (timeout);
endmodule : rltm_core

// file: tb/rltm_afe_model.sv
`timescale 1ns/1ps
// Front-end stand-in: answers every start after a programmable lag
module rltm_afe_model (
  // Link clock and reset
  input wire logic afe_clk,
  input wire logic afe_rst_n,
  // Request and answer lag
  input wire logic afe_start,
  input wire logic afe_channel,
  input wire logic [7:0] lag,
  // Values to report
  input wire logic [10:0] loc_val,
  input wire logic [13:0] raw_val,
  input wire logic [13:0] filt_val,
  // Results
  output logic afe_done,
  output logic [10:0] afe_local,
  output logic [13:0] afe_remote_raw,
  output logic [13:0] afe_remote_filt
);
  logic [8:0] cnt;
  logic [38:0] res;
  logic ch_q;
  assign {afe_local, afe_remote_raw, afe_remote_filt} = res;
  // Results flip every cycle outside done, so a stale value never passes for fresh
  always_ff @(posedge afe_clk) begin
    if (!afe_rst_n) begin
      cnt <= 9'h000;
      ch_q <= 1'b0;
      afe_done <= 1'b0;
      res <= '0;
    end else begin
      afe_done <= (cnt == 9'h001);
      // Only the requested channel reports true values, so a channel mix-up shows
      if (cnt != 9'h001) res <= ~res;
      else if (ch_q) res <= {~loc_val, raw_val, filt_val};
      else res <= {loc_val, ~raw_val, ~filt_val};
      if (afe_start) ch_q <= afe_channel;
      if (afe_start) cnt <= {1'b0, lag} + 9'h001;
      else if (cnt != 9'h000) cnt <= cnt - 9'h001;
    end
  end
endmodule : rltm_afe_model

// file: tb/rltm_core_test.sv
`timescale 1ns/1ps
`define CHK(nm, g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module rltm_core_test;
  localparam int P = 32;
  logic ref_clk = 1'b0, rst_n = 1'b0, afe_clk = 1'b0, afe_rst_n = 1'b0;
  logic scl = 1'b1, sda_h = 1'b1;
  logic [1:0] lvl = rltm_pkg::LVL_HIGH;
  logic [6:0] a7 = 7'h4C;
  logic [7:0] lag = 8'h03;
  // Local 25 C; remote raw 86 C, filtered 84 C plus fraction
  logic [10:0] loc_v = 11'h0C8;
  logic [13:0] raw_v = 14'h0AC0, filt_v = 14'h0A89;
  logic smb_dat_out, smb_dat_oe, critical_alert_out_n_out, critical_alert_out_n_oe;
  logic shared_alert_address_pin_out, shared_alert_address_pin_oe, afe_power_down;
  logic remote_filter_on, afe_start, afe_channel, afe_done;
  logic [10:0] afe_local;
  logic [13:0] afe_remote_raw, afe_remote_filt;
  int mismatches = 0, cmp_count = 0;
  // Open-drain data line: anyone pulling low wins
  wire sda = sda_h & ~(smb_dat_oe & ~smb_dat_out);
  always #4 ref_clk = ~ref_clk;
  // Link clock, phase unrelated to the reference clock
  initial begin
    #3;
    forever #40 afe_clk = ~afe_clk;
  end
  rltm_core #(.CYCLE_CYC_P(2000), .TIMEOUT_CYC_P(2000), .ALT_ADDR(1'b0)) u_dut (
    .ref_clk, .rst_n, .afe_clk, .afe_rst_n, .smb_clk_in(scl), .smb_dat_in(sda),
    .smb_dat_out, .smb_dat_oe, .addr_level_in(lvl), .critical_alert_out_n_out,
    .critical_alert_out_n_oe, .shared_alert_address_pin_out, .shared_alert_address_pin_oe,
    .afe_power_down, .remote_filter_on, .afe_start, .afe_channel, .afe_done, .afe_local,
    .afe_remote_raw, .afe_remote_filt);
  rltm_afe_model u_afe (.afe_clk, .afe_rst_n, .afe_start, .afe_channel, .lag,
    .loc_val(loc_v), .raw_val(raw_v), .filt_val(filt_v), .afe_done, .afe_local,
    .afe_remote_raw, .afe_remote_filt);
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt
  // Start (1,0) or stop (0,1): data set to a, clock raised, then data moves to b while the clock is high
  task automatic cond(input logic a, input logic b);
    wt(P / 2);
    sda_h = a;
    wt(P / 2);
    scl = 1'b1;
    wt(P);
    sda_h = b;
    wt(P);
    scl = b;
  endtask : cond
  // One bit; data changes mid-low so the sampler never sees a false start
  task automatic bt(input logic b, output logic r);
    wt(P / 2);
    sda_h = b;
    wt(P / 2);
    scl = 1'b1;
    wt(P);
    r = sda;
    scl = 1'b0;
  endtask : bt
  task automatic tx(input logic [7:0] d, output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    k = ~r;
  endtask : tx
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic k0, k1, k2;
    cond(1'b1, 1'b0);
    tx({a7, 1'b0}, k0);
    tx(p, k1);
    tx(d, k2);
    cond(1'b0, 1'b1);
    `CHK("write ack", {k0, k1, k2}, 3'b111)
  endtask : wr
  // Pointer set, repeated start, one byte read, host not-acknowledge
  task automatic rd(input logic [15:0] pe);
    logic k0, k1, k2, r;
    logic [7:0] v;
    cond(1'b1, 1'b0);
    tx({a7, 1'b0}, k0);
    tx(pe[15:8], k1);
    cond(1'b1, 1'b0);
    tx({a7, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) bt(1'b1, v[i]);
    bt(1'b1, r);
    cond(1'b0, 1'b1);
    `CHK($sformatf("reg %h", pe[15:8]), {k0, k1, k2, v}, {3'b111, pe[7:0]})
  endtask : rd
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // The sequence needs about 600 us; 800 us means a hang
  initial begin
    #800_000;
    mismatches++;
    complete_run();
  end
  initial begin
    logic k;
    static logic [7:0] ab = 8'h98;
    static logic [15:0] dflt[6] = '{16'h0300, 16'h0402, 16'hBF1F, 16'h0755, 16'h196E, 16'h2055};
    static logic [15:0] stby[5] = '{16'h0019, 16'h0154, 16'h1048, 16'h3154, 16'h0200};
    static logic [15:0] shot[4] = '{16'h0211, 16'h0156, 16'h1000, 16'h2014};
    wt(10);
    rst_n = 1'b1;
    wt(30);
    afe_rst_n = 1'b1;
    wt(20);
    `CHK("alerts idle", {critical_alert_out_n_oe, shared_alert_address_pin_oe}, 2'b00)
    foreach (dflt[i]) rd(dflt[i]);
    wr(8'h03, 8'h40);
    foreach (stby[i]) rd(stby[i]);
    wr(8'h20, 8'h94);
    wr(8'hBF, 8'h19);
    rd(16'h1040);
    `CHK("standby", {afe_power_down, critical_alert_out_n_oe, remote_filter_on}, 3'b100)
    lag = 8'h28;
    wr(8'h0F, 8'hA5);
    for (int i = 0; i < 4000 && critical_alert_out_n_oe !== 1'b1; i++) wt(1);
    `CHK("alert pins", {critical_alert_out_n_oe, critical_alert_out_n_out, shared_alert_address_pin_oe}, 3'b100)
    foreach (shot[i]) rd(shot[i]);
    cond(1'b1, 1'b0);
    tx({7'h18, 1'b0}, k);
    cond(1'b0, 1'b1);
    `CHK("foreign address ack", k, 1'b0)
    lvl = rltm_pkg::LVL_LOW;
    a7 = 7'h18;
    rd(16'h0340);
    wr(8'hBF, 8'h09);
    lvl = rltm_pkg::LVL_MID;
    a7 = 7'h29;
    rd(16'hBF19);
    lvl = rltm_pkg::LVL_HIGH;
    a7 = 7'h4C;
    wr(8'hBF, 8'h09);
    wt(8);
    `CHK("shared", {shared_alert_address_pin_oe, shared_alert_address_pin_out}, 2'b10)
    lvl = rltm_pkg::LVL_LOW;
    rd(16'hBF09);
    wr(8'h03, 8'h4F);
    wr(8'h0F, 8'h00);
    for (int i = 0; i < 4000 && critical_alert_out_n_oe !== 1'b0; i++) wt(1);
    wt(2);
    `CHK("masked", {critical_alert_out_n_oe, shared_alert_address_pin_oe}, 2'b00)
    // Stall the clock low under an acknowledge until the slave gives up
    cond(1'b1, 1'b0);
    for (int i = 7; i >= 0; i--) bt(ab[i], k);
    wt(8);
    `CHK("ack before stall", smb_dat_oe, 1'b1)
    wt(2100);
    `CHK("stall release", smb_dat_oe, 1'b0)
    sda_h = 1'b1;
    wt(P);
    scl = 1'b1;
    wt(P);
    rd(16'hBF09);
    complete_run();
  end
endmodule : rltm_core_test
